// [core/dbp_parity.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Odd parity on data and register paths
// - Writes: controller generates, drive checks data parity
// - Reads, write-checks: drive generates, controller checks
// - Parity bit travels through FIFO with data
// - Check spans 18 buffer bits plus parity
// - Sample data fault at latch trailing edge
// - Data fault holds until fault clear or controller init
// - Writes: parity zeroed, stream bit on even
// - Aborted fill sends zeros with parity set
// - Stream parity driven only during writes
// - Register write parity set on even ones
// - Register read fault at read-gate trailing edge
// - Register fault holds until fault clear or controller init
// - No register check on summary read
// - Data fault shows second bit 8, first bit 15
// - Register fault shows first bits 13, 15
// - Test select flips generated and stream sense
// - Two separate fault indicators
module dbp_parity
  import dbp_pkg::*;
#(
  parameter int DEPTH = dbp_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          link_clk,
  input  wire logic                          write_mode,
  input  wire logic                          stream_driver_enable,
  input  wire logic                          parity_test_select,
  input  wire logic                          fault_clear_n,
  input  wire logic                          ctrl_init,
  input  wire logic [dbp_pkg::STREAM_W-1:0]  host_word,
  input  wire logic                          host_word_valid,
  output logic                               host_word_ready,
  input  wire logic                          bus_data_latch_pulse,
  output logic [dbp_pkg::STREAM_W-1:0]       output_word_buffer,
  output logic                               buffer_parity_bit,
  output logic                               output_word_buffer_loaded,
  input  wire logic [dbp_pkg::STREAM_W-1:0]  stream_data_in,
  input  wire logic                          stream_parity_in,
  input  wire logic                          stream_in_valid,
  output logic                               stream_in_ready,
  output logic [dbp_pkg::STREAM_W-1:0]       stream_data_out,
  output logic                               stream_parity_bit,
  output logic                               stream_parity_oe,
  output logic                               stream_out_valid,
  input  wire logic                          stream_out_ready,
  input  wire logic [dbp_pkg::REG_W-1:0]     host_reg_data,
  output logic                               register_parity_tx,
  input  wire logic [dbp_pkg::REG_W-1:0]     reg_rx_data,
  input  wire logic                          register_parity_rx,
  input  wire logic                          register_read_gate_n,
  input  wire logic                          summary_read_select,
  output logic                               stream_parity_fault,
  output logic                               register_parity_fault,
  output logic [dbp_pkg::CSR_W-1:0]          first_control_status,
  output logic [dbp_pkg::CSR_W-1:0]          second_control_status,
  output logic                               led_register_fault,
  output logic                               led_stream_fault
);
  import dbp_pkg::*;

  if (DEPTH < 4) begin : g_depth_check
    $error("dbp_parity: DEPTH must be at least 4");
  end

  // Link domain reset and control levels
  logic                rst_s1_ff;
  logic                link_rst_ff;
  logic                wm_s1_ff;
  logic                wm_s2_ff;
  logic                en_s1_ff;
  logic                en_s2_ff;
  logic                pt_s1_ff;
  logic                pt_s2_ff;

  always_ff @(posedge link_clk) begin
    rst_s1_ff   <= rst;
    link_rst_ff <= rst_s1_ff;
    wm_s1_ff    <= write_mode;
    wm_s2_ff    <= wm_s1_ff;
    en_s1_ff    <= stream_driver_enable;
    en_s2_ff    <= en_s1_ff;
    pt_s1_ff    <= parity_test_select;
    pt_s2_ff    <= pt_s1_ff;
  end

  // Transfer FIFOs, one per direction, each word with its parity bit
  dbp_fifo_if #(.W(STREAM_ENT_W)) wq ();
  dbp_fifo_if #(.W(STREAM_ENT_W)) rq ();

  dbp_fifo #(.W(STREAM_ENT_W), .DEPTH(DEPTH)) u_wr_fifo (
    .wr_clk (clk),
    .wr_rst (rst),
    .rd_clk (link_clk),
    .rd_rst (link_rst_ff),
    .f      (wq.fifo)
  );

  dbp_fifo #(.W(STREAM_ENT_W), .DEPTH(DEPTH)) u_rd_fifo (
    .wr_clk (link_clk),
    .wr_rst (link_rst_ff),
    .rd_clk (clk),
    .rd_rst (rst),
    .f      (rq.fifo)
  );

  // Write path: buffered parity bit forced to zero
  assign wq.wr_valid    = host_word_valid && write_mode;
  assign wq.wr_data     = {1'b0, host_word};
  assign host_word_ready = wq.wr_ready && write_mode;

  // Link side write output
  logic                wq_take;
  logic [STREAM_W-1:0] nxt_sdata;

  assign wq_take     = wq.rd_valid && (!stream_out_valid || stream_out_ready);
  assign wq.rd_ready = wq_take && wm_s2_ff;
  assign nxt_sdata   = en_s2_ff ? wq.rd_data[STREAM_W-1:0] : RST_WORD;

  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      stream_data_out   <= RST_WORD;
      stream_parity_bit <= RST_FLAG;
      stream_out_valid  <= RST_FLAG;
    end else if (wq.rd_ready) begin
      stream_data_out   <= nxt_sdata;
      // Zero data is even, so parity is set
      stream_parity_bit <= ~(^{wq.rd_data[STREAM_W], nxt_sdata})
                           ^ pt_s2_ff;
      stream_out_valid  <= 1'b1;
    end else if (stream_out_ready) begin
      stream_out_valid  <= RST_FLAG;
    end
  end

  assign stream_parity_oe = wm_s2_ff;

  // Link side read input: drive's parity kept with the word
  assign rq.wr_valid   = stream_in_valid && !wm_s2_ff;
  assign rq.wr_data    = {stream_parity_in, stream_data_in};
  assign stream_in_ready = rq.wr_ready && !wm_s2_ff;

  // Output word buffer
  logic latch_d_ff;
  logic latch_fall;

  assign latch_fall  = latch_d_ff && !bus_data_latch_pulse;
  assign rq.rd_ready = !output_word_buffer_loaded && !write_mode;

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_d_ff <= RST_FLAG;
    end else begin
      latch_d_ff <= bus_data_latch_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_word_buffer <= RST_WORD;
      buffer_parity_bit  <= RST_FLAG;
      output_word_buffer_loaded        <= RST_FLAG;
    end else if (rq.rd_ready && rq.rd_valid) begin
      output_word_buffer <= rq.rd_data[STREAM_W-1:0];
      buffer_parity_bit  <= rq.rd_data[STREAM_W];
      output_word_buffer_loaded        <= 1'b1;
    end else if (latch_fall) begin
      output_word_buffer_loaded        <= RST_FLAG;
    end
  end

  // Stream parity fault
  logic clr_req;
  logic stream_bad;
  logic stream_set;

  assign clr_req    = !fault_clear_n || ctrl_init;
  assign stream_bad = ~(^{buffer_parity_bit, output_word_buffer}
                        ^ parity_test_select);
  assign stream_set = latch_fall && !write_mode && !stream_parity_fault
                      && stream_bad;

  always_ff @(posedge clk) begin
    if (rst) begin
      stream_parity_fault <= RST_FLAG;
    end else if (stream_set) begin
      stream_parity_fault <= 1'b1;
    end else if (clr_req) begin
      stream_parity_fault <= RST_FLAG;
    end
  end

  // Register path: write parity
  always_ff @(posedge clk) begin
    if (rst) begin
      register_parity_tx <= RST_FLAG;
    end else begin
      register_parity_tx <= ~(^host_reg_data)
                            ^ parity_test_select;
    end
  end

  // Register path: read check on synchronised pins
  logic [REG_W-1:0] rx_s1_ff;
  logic [REG_W-1:0] rx_s2_ff;
  logic             rp_s1_ff;
  logic             rp_s2_ff;
  logic             gate_s1_ff;
  logic             gate_s2_ff;
  logic             gate_d_ff;
  logic             as_s1_ff;
  logic             as_s2_ff;
  logic             gate_trail;
  logic             reg_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1_ff   <= '0;
      rx_s2_ff   <= '0;
      rp_s1_ff   <= RST_FLAG;
      rp_s2_ff   <= RST_FLAG;
      gate_s1_ff <= 1'b1;
      gate_s2_ff <= 1'b1;
      gate_d_ff  <= 1'b1;
      as_s1_ff   <= RST_FLAG;
      as_s2_ff   <= RST_FLAG;
    end else begin
      rx_s1_ff   <= reg_rx_data;
      rx_s2_ff   <= rx_s1_ff;
      rp_s1_ff   <= register_parity_rx;
      rp_s2_ff   <= rp_s1_ff;
      gate_s1_ff <= register_read_gate_n;
      gate_s2_ff <= gate_s1_ff;
      gate_d_ff  <= gate_s2_ff;
      as_s1_ff   <= summary_read_select;
      as_s2_ff   <= as_s1_ff;
    end
  end

  // Gate is active low; its trailing edge is the rise
  assign gate_trail = !gate_d_ff && gate_s2_ff;
  assign reg_set    = gate_trail && !as_s2_ff
                      && !(^{rp_s2_ff, rx_s2_ff});

  always_ff @(posedge clk) begin
    if (rst) begin
      register_parity_fault <= RST_FLAG;
    end else if (reg_set) begin
      register_parity_fault <= 1'b1;
    end else if (clr_req) begin
      register_parity_fault <= RST_FLAG;
    end
  end

  // Status words
  always_comb begin
    first_control_status = RST_CSR;
    first_control_status[FIRST_CPE_POS] = register_parity_fault;
    first_control_status[FIRST_TOP_POS] = register_parity_fault
                                          || stream_parity_fault;
    second_control_status = RST_CSR;
    second_control_status[SECOND_DPE_POS] = stream_parity_fault;
    second_control_status[SECOND_PTS_POS] = parity_test_select;
  end

  assign led_register_fault = register_parity_fault;
  assign led_stream_fault   = stream_parity_fault;
endmodule : dbp_parity
`default_nettype wire

// [core/dbp_pkg.sv]
package dbp_pkg;
  // Word widths on the drive cable
  localparam int STREAM_W     = 18;
  localparam int STREAM_ENT_W = STREAM_W + 1;
  localparam int REG_W        = 16;
  localparam int CSR_W        = 16;
  // Transfer FIFO depth
  localparam int FIFO_DEPTH   = 16;
  // Status bit positions
  localparam int SECOND_DPE_POS = 8;
  localparam int SECOND_PTS_POS = 4;
  localparam int FIRST_CPE_POS  = 13;
  localparam int FIRST_TOP_POS  = 15;
  // Reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic [STREAM_W-1:0] RST_WORD = 18'h00000;
  localparam logic [CSR_W-1:0] RST_CSR = 16'h0000;
endpackage : dbp_pkg

// [core/dbp_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dbp_fifo_if #(
  parameter int W = 19
);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
  modport src (output wr_valid, output wr_data, input wr_ready);
  modport snk (input rd_valid, input rd_data, output rd_ready);
endinterface : dbp_fifo_if
`default_nettype wire

// [core/dbp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// Dual-clock FIFO with gray-coded pointers
module dbp_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 16
) (
  input  wire logic wr_clk,
  input  wire logic wr_rst,
  input  wire logic rd_clk,
  input  wire logic rd_rst,
  dbp_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);

  // Full test needs two pointer bits below the wrap bit
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("dbp_fifo: DEPTH must be a power of two, at least 4");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wr_bin_ff;
  logic [AW:0]   wr_gray_ff;
  logic [AW:0]   rd_bin_ff;
  logic [AW:0]   rd_gray_ff;
  logic [AW:0]   rg_s1_ff;
  logic [AW:0]   rg_s2_ff;
  logic [AW:0]   wg_s1_ff;
  logic [AW:0]   wg_s2_ff;
  logic [AW:0]   nxt_wr_bin;
  logic [AW:0]   nxt_rd_bin;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  assign full  = (wr_gray_ff == {~rg_s2_ff[AW:AW-1], rg_s2_ff[AW-2:0]});
  assign empty = (rd_gray_ff == wg_s2_ff);
  assign push  = f.wr_valid && !full;
  assign pop   = f.rd_ready && !empty;
  assign nxt_wr_bin = wr_bin_ff + (AW+1)'(push);
  assign nxt_rd_bin = rd_bin_ff + (AW+1)'(pop);
  assign f.wr_ready = !full;
  assign f.rd_valid = !empty;
  assign f.rd_data  = mem[rd_bin_ff[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wr_bin_ff[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wr_bin_ff  <= '0;
      wr_gray_ff <= '0;
      rg_s1_ff   <= '0;
      rg_s2_ff   <= '0;
    end else begin
      wr_bin_ff  <= nxt_wr_bin;
      wr_gray_ff <= nxt_wr_bin ^ (nxt_wr_bin >> 1);
      rg_s1_ff   <= rd_gray_ff;
      rg_s2_ff   <= rg_s1_ff;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rd_bin_ff  <= '0;
      rd_gray_ff <= '0;
      wg_s1_ff   <= '0;
      wg_s2_ff   <= '0;
    end else begin
      rd_bin_ff  <= nxt_rd_bin;
      rd_gray_ff <= nxt_rd_bin ^ (nxt_rd_bin >> 1);
      wg_s1_ff   <= wr_gray_ff;
      wg_s2_ff   <= wg_s1_ff;
    end
  end
endmodule : dbp_fifo
`default_nettype wire

// [test/dbp_parity_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dbp_parity_asserts (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         write_mode,
  input wire logic                         parity_test_select,
  input wire logic                         fault_clear_n,
  input wire logic                         ctrl_init,
  input wire logic                         bus_data_latch_pulse,
  input wire logic [dbp_pkg::STREAM_W-1:0] output_word_buffer,
  input wire logic                         buffer_parity_bit,
  input wire logic                         output_word_buffer_loaded,
  input wire logic [dbp_pkg::REG_W-1:0]    host_reg_data,
  input wire logic                         register_parity_tx,
  input wire logic                         stream_parity_fault,
  input wire logic                         register_parity_fault,
  input wire logic [dbp_pkg::CSR_W-1:0]    first_control_status,
  input wire logic [dbp_pkg::CSR_W-1:0]    second_control_status,
  input wire logic                         led_register_fault,
  input wire logic                         led_stream_fault
);
  import dbp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Trailing edge of the data latch pulse
  sequence latch_fall;
    bus_data_latch_pulse ##1 !bus_data_latch_pulse;
  endsequence
  // Trailing edge over a loaded read word that fails the check
  sequence bad_fall;
    latch_fall ##0 (!write_mode && output_word_buffer_loaded &&
      ((^{output_word_buffer, buffer_parity_bit}) == parity_test_select));
  endsequence
  a_reg_tx_parity: assert property (
    !$past(rst) |-> register_parity_tx ==
      (~^$past(host_reg_data) ^ $past(parity_test_select)))
    else $error("register parity out wrong");
  a_stream_fault_set: assert property (
    bad_fall |=> stream_parity_fault)
    else $error("stream fault not set");
  a_stream_fault_cause: assert property (
    $rose(stream_parity_fault) |-> $past(bus_data_latch_pulse, 2) &&
      !$past(bus_data_latch_pulse) && !$past(write_mode))
    else $error("stream fault set without cause");
  a_stream_fault_hold: assert property (
    stream_parity_fault && fault_clear_n && !ctrl_init
      |=> stream_parity_fault)
    else $error("stream fault lost");
  a_reg_fault_hold: assert property (
    register_parity_fault && fault_clear_n && !ctrl_init
      |=> register_parity_fault)
    else $error("register fault lost");
  a_stream_fault_clear: assert property (
    (!fault_clear_n || ctrl_init) && !$fell(bus_data_latch_pulse)
      |=> !stream_parity_fault)
    else $error("stream fault not cleared");
  a_status_bits: assert property (
    first_control_status == {stream_parity_fault | register_parity_fault,
      1'h0, register_parity_fault, 13'h0000} &&
      second_control_status[SECOND_DPE_POS] == stream_parity_fault)
    else $error("status bits wrong");
  a_fault_leds: assert property (
    led_register_fault == register_parity_fault &&
      led_stream_fault == stream_parity_fault)
    else $error("fault indicators wrong");
endmodule : dbp_parity_asserts
`default_nettype wire

// [test/dbp_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dbp_drive_model (
  input  wire logic                         link_clk,
  input  wire logic [dbp_pkg::STREAM_W-1:0] stream_data_out,
  input  wire logic                         stream_parity_bit,
  input  wire logic                         stream_out_valid,
  output var  logic                         stream_out_ready,
  output var  logic [dbp_pkg::STREAM_W-1:0] stream_data_in,
  output var  logic                         stream_parity_in,
  output var  logic                         stream_in_valid,
  input  wire logic                         stream_in_ready
);
  import dbp_pkg::*;
  logic              stall = 1'h0;
  logic [STREAM_W:0] got[$];
  initial begin
    stream_out_ready = 1'h0;
    stream_in_valid = 1'h0;
    stream_data_in = 18'h00000;
    stream_parity_in = 1'h0;
  end
  // Takes written words, stalling when asked
  always @(posedge link_clk) begin
    if (stream_out_valid && stream_out_ready) begin
      got.push_back({stream_parity_bit, stream_data_out});
    end
    stream_out_ready <= !stall;
  end
  // Sends one read word, odd parity unless a bad one is asked for
  task automatic send(input logic [STREAM_W-1:0] d, input logic bad);
    @(posedge link_clk);
    #2;
    stream_data_in = d;
    stream_parity_in = ~^d ^ bad;
    stream_in_valid = 1'h1;
    do @(posedge link_clk); while (!stream_in_ready);
    #2;
    stream_in_valid = 1'h0;
    stream_data_in = ~d;
    stream_parity_in = ~stream_parity_in;
  endtask : send
endmodule : dbp_drive_model
`default_nettype wire

// [test/dbp_parity_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dbp_parity_test;
  import dbp_pkg::*;
  logic clk, rst, link_clk, write_mode, stream_driver_enable, ctrl_init;
  logic parity_test_select, fault_clear_n, host_word_valid, host_word_ready;
  logic bus_data_latch_pulse, buffer_parity_bit, output_word_buffer_loaded, stream_in_ready;
  logic stream_parity_in, stream_in_valid, stream_parity_bit, led_stream_fault;
  logic stream_parity_oe, stream_out_valid, stream_out_ready;
  logic register_parity_tx, register_parity_rx, register_read_gate_n;
  logic summary_read_select, stream_parity_fault, register_parity_fault;
  logic led_register_fault;
  logic [STREAM_W-1:0] host_word, output_word_buffer, stream_data_in;
  logic [STREAM_W-1:0] stream_data_out;
  logic [REG_W-1:0]    host_reg_data, reg_rx_data;
  logic [CSR_W-1:0]    first_control_status, second_control_status;
  int                  errors, checks_done, cycles, n, i;
  dbp_parity #(.DEPTH(FIFO_DEPTH)) dbp_parity_i (.*);
  dbp_drive_model dbp_drive_model_i (.*);
  always #25 clk = ~clk;
  always #32 link_clk = ~link_clk;
  function automatic logic [STREAM_W:0] wexp(input logic [STREAM_W-1:0] d,
                                             input logic t);
    return {~^d ^ t, d};
  endfunction : wexp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  task automatic reg_read(input logic [REG_W-1:0] d, input logic p, s);
    reg_rx_data = d;
    register_parity_rx = p;
    summary_read_select = s;
    register_read_gate_n = 1'h0;
    cyc(4);
    register_read_gate_n = 1'h1;
    cyc(6);
    reg_rx_data = ~d;
    register_parity_rx = ~p;
  endtask : reg_read
  task automatic readw(input logic [STREAM_W-1:0] d, input logic bad);
    dbp_drive_model_i.send(d, bad);
    while (!output_word_buffer_loaded) cyc(1);
    chk({buffer_parity_bit, output_word_buffer}, wexp(d, bad));
    bus_data_latch_pulse = 1'h1;
    cyc(1);
    bus_data_latch_pulse = 1'h0;
    cyc(2);
  endtask : readw
  task automatic push(input logic [STREAM_W-1:0] d);
    host_word = d;
    host_word_valid = 1'h1;
    while (!host_word_ready) cyc(1);
    cyc(1);
  endtask : push
  task automatic complete_run;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t ns: run timed out", $time);
      complete_run;
    end
  end
  initial begin
    {clk, link_clk, write_mode, parity_test_select, ctrl_init} = 5'h00;
    {host_word_valid, bus_data_latch_pulse, summary_read_select} = 3'h0;
    {rst, stream_driver_enable, fault_clear_n} = 3'h7;
    {register_read_gate_n, register_parity_rx} = 2'h2;
    {host_word, host_reg_data, reg_rx_data} = 50'h0;
    {errors, checks_done, cycles} = 96'h0;
    cyc(16);
    rst = 1'h0;
    cyc(4);
    chk({first_control_status, second_control_status}, 32'h0);
    for (i = 0; i < 8; i++) begin
      host_reg_data = 16'h00FF >> i;
      parity_test_select = i[1];
      cyc(2);
      chk(register_parity_tx, ~^host_reg_data ^ i[1]);
    end
    parity_test_select = 1'h0;
    reg_read(16'hFFFF, 1'h1, 1'h0);
    chk(register_parity_fault, 1'h0);
    reg_read(16'h00FF, 1'h0, 1'h1);
    chk(register_parity_fault, 1'h0);
    reg_read(16'h00FF, 1'h0, 1'h0);
    chk(first_control_status, 16'hA000);
    reg_read(16'hFFFF, 1'h1, 1'h0);
    chk({register_parity_fault, led_register_fault}, 2'h3);
    fault_clear_n = 1'h0;
    cyc(1);
    fault_clear_n = 1'h1;
    cyc(1);
    chk(register_parity_fault, 1'h0);
    readw(18'h3FFFF, 1'h0);
    chk(stream_parity_fault, 1'h0);
    readw(18'h00001, 1'h1);
    chk({first_control_status, second_control_status}, 32'h80000100);
    readw(18'h00003, 1'h0);
    chk(led_stream_fault, 1'h1);
    ctrl_init = 1'h1;
    cyc(1);
    ctrl_init = 1'h0;
    cyc(1);
    chk(stream_parity_fault, 1'h0);
    parity_test_select = 1'h1;
    readw(18'h00005, 1'h1);
    chk(second_control_status, 16'h0010);
    parity_test_select = 1'h0;
    dbp_drive_model_i.stall = 1'h1;
    write_mode = 1'h1;
    cyc(10);
    chk(stream_parity_oe, 1'h1);
    n = 0;
    while (host_word_ready && n < 40) begin
      push(18'h3FFFF >> n);
      n++;
    end
    host_word_valid = 1'h0;
    chk(n >= FIFO_DEPTH, 1'h1);
    dbp_drive_model_i.stall = 1'h0;
    cyc(150);
    chk(dbp_drive_model_i.got.size(), n);
    for (i = 0; i < n; i++) begin
      chk(dbp_drive_model_i.got[i], wexp(18'h3FFFF >> i, 1'h0));
    end
    parity_test_select = 1'h1;
    push(18'h00003);
    host_word_valid = 1'h0;
    cyc(60);
    chk(dbp_drive_model_i.got[n], wexp(18'h00003, 1'h1));
    parity_test_select = 1'h0;
    stream_driver_enable = 1'h0;
    cyc(4);
    push(18'h00007);
    host_word_valid = 1'h0;
    cyc(60);
    chk(dbp_drive_model_i.got[n + 1], 19'h40000);
    stream_driver_enable = 1'h1;
    write_mode = 1'h0;
    cyc(10);
    chk(stream_parity_oe, 1'h0);
    complete_run;
  end
endmodule : dbp_parity_test
bind dbp_parity dbp_parity_asserts dbp_parity_asserts_i (.*);
`default_nettype wire
